// >>> src/lsw_top.sv
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bit 0 is 1 while the link is up, low power idle included, and 0 when it is down.
// - The speed field reads 0 without negotiation complete, with serial flag, or no common mode.
// - A 10BASE-T link is coded 1 for half and 2 for full duplex.
// - A 100BASE-TX link is coded 3 for half and 5 for full duplex.
// - A 1000BASE-T half-duplex link is coded 6.
// - A 10 Gbps link is coded 8.
// - When higher rates are enabled, 20 Gbps is coded 9 and 25 Gbps is coded A.
// - When higher rates are enabled, 50 Gbps is coded C.
// - Code F marks an extended rate while the extension control bit is set; the word has no extended field, bits 24 up read 0.
// - An unlisted medium or rate reports the 100BASE-TX code for its duplex (3 or 5), not a media type.
// - Bit 5 is 1 while auto-negotiation is enabled on the link.
// - Bit 5 is forced to 0 when negotiation is unsupported, disabled, or link is not Ethernet.
// - Every valid link status query is accepted; only a good one is answered with the status word.
module lsw_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // PHY state pins
    input  wire logic        phy_link_up,
    input  wire logic        phy_lpi,
    input  wire logic [3:0]  phy_rate,
    input  wire logic        phy_full_duplex,
    input  wire logic        phy_an_complete,
    input  wire logic        phy_an_enabled,
    input  wire logic        phy_is_ethernet,
    input  wire logic        serial_interface_flag,
    input  wire logic        highest_common_mode,
    // Query from packet engine, same clock
    input  wire logic        query_valid,
    input  wire logic        query_good,
    output logic             query_ready,
    // Response to packet engine
    output logic             resp_valid,
    input  wire logic        resp_ready,
    output logic [31:0]      resp_word,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Interrupt
    output logic             irq
);
    import lsw_pkg::*;

    // Width of the synchronised pin vector
    localparam int PW = 13;

    // Query engine states
    typedef enum logic [1:0] {LSW_IDLE, LSW_RESP} lsw_state_e;

    logic [PW-1:0]        phy_raw;
    logic [PW-1:0]        phy_s;
    logic [3:0]           rate_s;
    logic                 link_s;
    logic                 lpi_s;
    logic                 fd_s;
    logic                 anc_s;
    logic                 anen_s;
    logic                 eth_s;
    logic                 serdes_s;
    logic                 hcm_s;
    logic [3:0]           spd_code;
    logic [31:0]          live_word;
    logic [31:0]          ctrl;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;
    logic [IRQ_W-1:0]     irq_set;
    logic                 link_prev;
    lsw_state_e           state;
    logic                 aw_hold;
    logic                 w_hold;
    logic [7:0]           aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 wr_fire;
    logic                 rd_fire;
    logic                 resp_done;
    logic                 query_take;
    logic                 wr_ctrl;
    logic                 wr_mask;
    logic                 wr_stat;

    // Byte-lane merge of a write into a word
    function automatic logic [31:0] lsw_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Word-aligned register decode, shared by the write strobes
    function automatic logic lsw_hit(input logic [7:0] addr,
                                     input logic [7:0] offs);
        logic [7:0] word_addr;
        word_addr = addr & 8'hFC;
        return word_addr == offs;
    endfunction

    // Pin bundle through the synchroniser
    assign phy_raw = {phy_link_up, phy_lpi, phy_rate, phy_full_duplex, phy_an_complete,
                      phy_an_enabled, phy_is_ethernet, serial_interface_flag,
                      highest_common_mode, 1'b0};

    lsw_sync #(
        .W (PW)
    ) lsw_sync_i (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (phy_raw),
        .dout    (phy_s)
    );

    // Unpack synchronised state
    assign link_s   = phy_s[12];
    assign lpi_s    = phy_s[11];
    assign rate_s   = phy_s[10:7];
    assign fd_s     = phy_s[6];

    // Negotiation and medium flags
    assign anc_s    = phy_s[5];
    assign anen_s   = phy_s[4];
    assign eth_s    = phy_s[3];
    assign serdes_s = phy_s[2];
    assign hcm_s    = phy_s[1];

    lsw_speed_enc lsw_speed_enc_i (
        .rate                  (rate_s),
        .full_duplex           (fd_s),
        .an_complete           (anc_s),
        .serial_interface_flag (serdes_s),
        .highest_common_mode   (hcm_s),
        .high_rate_en          (ctrl[CTRL_HIGHRATE_BIT]),
        .ext_en                (ctrl[CTRL_EXT_BIT]),
        .code                  (spd_code)
    );

    // Live status word assembly
    always_comb begin
        live_word = 32'h0000_0000;
        live_word[LINK_BIT] = link_s | (link_s & lpi_s);
        live_word[SPD_LSB +: SPD_W] = link_s ? spd_code : SPD_NONE;
        live_word[ANEN_BIT] = anen_s & eth_s & ctrl[CTRL_ANSUP_BIT];
    end

    // Query handshake: every query with a clean check is answered
    assign query_ready = (state == LSW_IDLE);
    assign query_take  = query_valid & query_ready;
    assign resp_done   = resp_valid & resp_ready;

    // Response state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= LSW_IDLE;
        end else begin
            case (state)
                LSW_IDLE: begin
                    if (query_take && query_good) begin
                        state <= LSW_RESP;
                    end
                end
                LSW_RESP: begin
                    if (resp_done) begin
                        state <= LSW_IDLE;
                    end
                end
                default: state <= LSW_IDLE;
            endcase
        end
    end

    // Response pending until the reader takes it
    assign resp_valid = (state == LSW_RESP);

    // Snapshot of the word at the moment of the query
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            resp_word <= 32'h0000_0000;
        end else if (query_take && query_good) begin
            resp_word <= live_word;
        end
    end

    // Write channel capture
    assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
    assign wr_fire       = aw_hold & w_hold & ~s_axi_bvalid;

    // Register write strobes, byte lane 0 carries the interrupt bits
    assign wr_ctrl = wr_fire & lsw_hit(aw_addr, REG_CTRL);
    assign wr_mask = wr_fire & lsw_hit(aw_addr, REG_IRQ_MASK) & w_strb[0];
    assign wr_stat = wr_fire & lsw_hit(aw_addr, REG_IRQ_STAT) & w_strb[0];

    // Hold address and data until both halves have arrived
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr & 8'hFC)
                REG_CTRL, REG_IRQ_STAT, REG_IRQ_MASK: s_axi_bresp <= RESP_OKAY;
                REG_STATUS, REG_PHY:                  s_axi_bresp <= RESP_OKAY;
                default:                              s_axi_bresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= lsw_merge(ctrl, w_data, w_strb) & 32'h0000_0007;
        end
    end

    // Interrupt mask register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= w_data[IRQ_W-1:0];
        end
    end

    // Interrupt events: response sent, link change, rejected query
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_prev <= 1'b0;
        end else begin
            link_prev <= link_s;
        end
    end

    // One-cycle event pulses
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_RESP_BIT] = resp_done;
        irq_set[IRQ_LINK_BIT] = link_s ^ link_prev;
        irq_set[IRQ_REJ_BIT]  = query_take & ~query_good;
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= '0;
        end else if (wr_stat) begin
            irq_stat <= (irq_stat & ~w_data[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    // Level interrupt from any unmasked status bit
    assign irq = |(irq_stat & irq_mask);

    // Read channel
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid & s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr & 8'hFC)
                REG_STATUS:   s_axi_rdata <= live_word;
                REG_CTRL:     s_axi_rdata <= ctrl;
                REG_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
                REG_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
                REG_PHY:      s_axi_rdata <= {19'h0, phy_s};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// >>> src/lsw_pkg.sv
package lsw_pkg;

    // Status word field positions
    localparam int LINK_BIT      = 0;
    localparam int SPD_LSB       = 1;
    localparam int SPD_W         = 4;
    localparam int ANEN_BIT      = 5;

    // Speed and duplex codes
    localparam logic [3:0] SPD_NONE    = 4'h0;
    localparam logic [3:0] SPD_10_HD   = 4'h1;
    localparam logic [3:0] SPD_10_FD   = 4'h2;
    localparam logic [3:0] SPD_100_HD  = 4'h3;
    localparam logic [3:0] SPD_100_FD  = 4'h5;
    localparam logic [3:0] SPD_1G_HD   = 4'h6;
    localparam logic [3:0] SPD_10G     = 4'h8;
    localparam logic [3:0] SPD_20G     = 4'h9;
    localparam logic [3:0] SPD_25G     = 4'hA;
    localparam logic [3:0] SPD_50G     = 4'hC;
    localparam logic [3:0] SPD_EXT     = 4'hF;

    // Resolved rate index from the PHY
    localparam logic [3:0] RATE_NONE   = 4'h0;
    localparam logic [3:0] RATE_10M    = 4'h1;
    localparam logic [3:0] RATE_100M   = 4'h2;
    localparam logic [3:0] RATE_1G     = 4'h3;
    localparam logic [3:0] RATE_10G    = 4'h4;
    localparam logic [3:0] RATE_20G    = 4'h5;
    localparam logic [3:0] RATE_25G    = 4'h6;
    localparam logic [3:0] RATE_50G    = 4'h7;
    localparam logic [3:0] RATE_EXT    = 4'h8;
    localparam logic [3:0] RATE_OTHER  = 4'h9;

    // Register byte offsets
    localparam logic [7:0] REG_STATUS   = 8'h00;
    localparam logic [7:0] REG_CTRL     = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_PHY      = 8'h10;

    // Control register fields and reset
    localparam int CTRL_HIGHRATE_BIT = 0;
    localparam int CTRL_ANSUP_BIT    = 1;
    localparam int CTRL_EXT_BIT      = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;

    // Interrupt event bits
    localparam int IRQ_W         = 3;
    localparam int IRQ_RESP_BIT  = 0;
    localparam int IRQ_LINK_BIT  = 1;
    localparam int IRQ_REJ_BIT   = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> src/lsw_speed_enc.sv
`timescale 1ns/1ps
`default_nettype none
module lsw_speed_enc (
    // Resolved link state and control enables
    input  wire logic [3:0] rate,
    input  wire logic       full_duplex,
    input  wire logic       an_complete,
    input  wire logic       serial_interface_flag,
    input  wire logic       highest_common_mode,
    input  wire logic       high_rate_en,
    input  wire logic       ext_en,
    // Code out
    output logic      [3:0] code
);
    import lsw_pkg::*;

    // Rate and duplex to speed and duplex code
    always_comb begin
        code = SPD_NONE;
        if (!an_complete || serial_interface_flag || !highest_common_mode) begin
            code = SPD_NONE;
        end else begin
            case (rate)
                RATE_10M:   code = full_duplex ? SPD_10_FD : SPD_10_HD;
                RATE_100M:  code = full_duplex ? SPD_100_FD : SPD_100_HD;
                RATE_1G:    code = full_duplex ? SPD_NONE : SPD_1G_HD;
                RATE_10G:   code = SPD_10G;
                RATE_20G:   code = high_rate_en ? SPD_20G : SPD_10G;
                RATE_25G:   code = high_rate_en ? SPD_25G : SPD_20G;
                RATE_50G:   code = high_rate_en ? SPD_50G : SPD_10G;
                RATE_EXT:   code = ext_en ? SPD_EXT : SPD_NONE;
                RATE_OTHER: code = full_duplex ? SPD_100_FD : SPD_100_HD;
                default:    code = SPD_NONE;
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> src/lsw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lsw_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;

    // Two-stage synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule
`default_nettype wire

// >>> tb/lsw_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lsw_chk (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // PHY state
    input  wire logic        phy_link_up,
    input  wire logic        phy_an_enabled,
    input  wire logic        serial_interface_flag,
    // Query and response
    input  wire logic        query_valid,
    input  wire logic        query_good,
    input  wire logic        query_ready,
    input  wire logic        resp_valid,
    input  wire logic        resp_ready,
    input  wire logic [31:0] resp_word
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Query taken with a clean check
    sequence s_take_good;
        query_valid && query_ready && query_good;
    endsequence

    // Pin held long enough to cross both synchroniser stages
    sequence s_calm(sig);
        $stable(sig) [*4];
    endsequence

    // Query acceptance and response handshake
    a_good_answered: assert property (s_take_good |=> resp_valid)
        else $error("good query not answered");
    a_bad_dropped: assert property (query_valid && query_ready && !query_good |=> !resp_valid)
        else $error("bad query answered");
    a_word_held: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_word))
        else $error("response dropped or changed while stalled");
    a_busy_no_take: assert property (resp_valid |-> !query_ready)
        else $error("query accepted with response pending");

    // Word contents against the pins at the query
    a_link_flag: assert property (s_calm(phy_link_up) ##0 s_take_good |=> resp_word[0] == $past(phy_link_up))
        else $error("link flag differs from link pin");
    a_down_no_code: assert property (resp_valid && !resp_word[0] |-> resp_word[4:1] == 4'h0)
        else $error("speed code reported with link down");
    a_serial_zero: assert property (s_calm(serial_interface_flag) ##0 s_take_good ##0 serial_interface_flag |=> resp_word[4:1] == 4'h0)
        else $error("speed code reported with serial flag set");
    a_anen_zero: assert property (s_calm(phy_an_enabled) ##0 s_take_good ##0 !phy_an_enabled |=> !resp_word[5])
        else $error("negotiation flag set while disabled");
endmodule

bind lsw_top lsw_chk lsw_chk_i (.*);
`default_nettype wire

// >>> tb/lsw_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none
module lsw_mgmt_model (
    // Clock
    input  wire logic        aclk,
    // Query out
    output logic             query_valid,
    output logic             query_good,
    input  wire logic        query_ready,
    // Response in
    input  wire logic        resp_valid,
    output logic             resp_ready,
    input  wire logic [31:0] resp_word
);
    // Idle levels
    initial begin
        query_valid = 1'b0;
        query_good  = 1'b0;
        resp_ready  = 1'b0;
    end

    // One query, then collect its answer after an optional stall
    task automatic query(input logic good, input int stall,
                         output logic [31:0] word, output logic got);
        int n;
        n = 0;
        got = 1'b0;
        word = 32'h0;
        query_valid <= 1'b1;
        query_good <= good;
        do begin
            @(negedge aclk);
            n++;
        end while (query_ready !== 1'b1 && n < 50);
        @(posedge aclk);
        query_valid <= 1'b0;
        query_good <= ~good;     // Qualifier is meaningless once taken
        resp_ready <= (stall == 0);
        for (n = 0; n < 20 && !got; n++) begin
            @(negedge aclk);
            if (resp_valid === 1'b1 && resp_ready === 1'b1) begin
                got = 1'b1;
                word = resp_word;
            end
            @(posedge aclk);
            resp_ready <= !got && (n + 1 >= stall);
        end
        // Code F would send the reader to the extended field
        if (word[4:1] === 4'hF) word[31:24] = resp_word[31:24];
    endtask
endmodule
`default_nettype wire

// >>> tb/test_link_status_word_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_link_status_word_encoder;
    import lsw_pkg::*;

    logic        aclk, aresetn, phy_link_up, phy_lpi, phy_full_duplex, irq;
    logic        phy_an_complete, phy_an_enabled, phy_is_ethernet;
    logic        serial_interface_flag, highest_common_mode;
    logic [3:0]  phy_rate, s_axi_wstrb;
    logic        query_valid, query_good, query_ready, resp_valid, resp_ready;
    logic [31:0] resp_word, s_axi_wdata, s_axi_rdata;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          err_total = 0;
    int          checks_done = 0;

    lsw_top        lsw_top_i (.*);
    lsw_mgmt_model lsw_mgmt_model_i (.*);

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Drive all PHY pins, then let the synchronisers settle
    task automatic set_phy(input logic [11:0] v);
        {phy_link_up, phy_lpi, phy_rate, phy_full_duplex, phy_an_complete,
         phy_an_enabled, phy_is_ethernet, serial_interface_flag, highest_common_mode} <= v;
        repeat (4) @(posedge aclk);
    endtask

    task automatic ask(input logic good, input int st, output logic [31:0] w);
        logic g;
        lsw_mgmt_model_i.query(good, st, w, g);
        chk(32'(g), 32'(good));
    endtask

    // AXI4-Lite write, address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        int   n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        for (n = 0; n < 50 && !b; n++) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = (s_axi_bvalid === 1'b1);
            if (b) chk(32'(s_axi_bresp), 32'(er));
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk(32'(b), 32'h1);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, r;
        int   n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 1'b0;
        for (n = 0; n < 50 && !r; n++) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = (s_axi_rvalid === 1'b1);
            if (r) chk(s_axi_rdata, ed);
            if (r) chk(32'(s_axi_rresp), 32'(er));
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk(32'(r), 32'h1);
    endtask

    // Register resets, unmapped access, rejected query and interrupt
    task automatic t_irq;
        logic [31:0] w;
        axi_rd(REG_CTRL, CTRL_RESET, RESP_OKAY);
        axi_rd(REG_IRQ_MASK, 32'h0, RESP_OKAY);
        axi_rd(8'h40, 32'h0, RESP_SLVERR);
        axi_wr(8'h40, 32'h1, RESP_SLVERR);
        axi_wr(REG_IRQ_STAT, 32'h7, RESP_OKAY);
        ask(1'b0, 0, w);
        axi_rd(REG_IRQ_STAT, 32'h4, RESP_OKAY);
        chk(32'(irq), 32'h0);
        axi_wr(REG_IRQ_MASK, 32'h4, RESP_OKAY);
        chk(32'(irq), 32'h1);
        axi_wr(REG_IRQ_STAT, 32'h4, RESP_OKAY);
        chk(32'(irq), 32'h0);
    endtask

    // Every listed speed and duplex code
    task automatic t_codes;
        logic [8:0]  tbl [11];
        logic [31:0] w;
        tbl = '{{RATE_10M, 1'b0, SPD_10_HD}, {RATE_10M, 1'b1, SPD_10_FD},
                {RATE_100M, 1'b0, SPD_100_HD}, {RATE_100M, 1'b1, SPD_100_FD},
                {RATE_1G, 1'b0, SPD_1G_HD}, {RATE_1G, 1'b1, SPD_NONE},
                {RATE_10G, 1'b1, SPD_10G}, {RATE_20G, 1'b1, SPD_20G},
                {RATE_25G, 1'b1, SPD_25G}, {RATE_50G, 1'b1, SPD_50G},
                {RATE_OTHER, 1'b1, SPD_100_FD}};
        foreach (tbl[i]) begin
            set_phy({2'b10, tbl[i][8:4], 5'b11101});
            ask(1'b1, 0, w);
            chk(32'(w[5:0]), 32'({1'b1, tbl[i][3:0], 1'b1}));
        end
        axi_wr(REG_CTRL, 32'h2, RESP_OKAY);
        set_phy({2'b10, RATE_25G, 1'b1, 5'b11101});
        ask(1'b1, 0, w);
        chk(32'(w[4:1]), 32'(SPD_20G));
        axi_wr(REG_CTRL, 32'h7, RESP_OKAY);
        set_phy({2'b10, RATE_EXT, 1'b1, 5'b11101});
        ask(1'b1, 0, w);
        chk(32'(w[4:1]), 32'(SPD_EXT));
        axi_rd(REG_STATUS, 32'h0000_003F, RESP_OKAY);
        axi_wr(REG_CTRL, CTRL_RESET, RESP_OKAY);
    endtask

    // Link flag, zeroed speed field and negotiation flag
    task automatic t_flags;
        logic [17:0] tbl [7];
        logic [31:0] w;
        tbl = '{{2'b00, RATE_1G, 1'b0, 5'b11101, 6'h20}, {2'b11, RATE_1G, 1'b0, 5'b11101, 6'h2D},
                {2'b10, RATE_1G, 1'b0, 5'b01101, 6'h21}, {2'b10, RATE_1G, 1'b0, 5'b11111, 6'h21},
                {2'b10, RATE_1G, 1'b0, 5'b11100, 6'h21}, {2'b10, RATE_1G, 1'b0, 5'b10101, 6'h0D},
                {2'b10, RATE_1G, 1'b0, 5'b11001, 6'h0D}};
        foreach (tbl[i]) begin
            set_phy(tbl[i][17:6]);
            ask(1'b1, 0, w);
            chk(32'(w[5:0]), 32'(tbl[i][5:0]));
        end
        axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
        set_phy({2'b10, RATE_1G, 1'b0, 5'b11101});
        ask(1'b1, 0, w);
        chk(32'(w[5]), 32'h0);
        chk(32'(w[4:0]), 32'h0000_000D);
        axi_wr(REG_CTRL, CTRL_RESET, RESP_OKAY);
    endtask

    // Stalled answer keeps the state seen at the query, then back to back
    task automatic t_snap;
        logic [31:0] w;
        set_phy({2'b10, RATE_100M, 1'b1, 5'b11101});
        fork
            ask(1'b1, 6, w);
            begin
                repeat (3) @(posedge aclk);
                phy_link_up <= 1'b0;
            end
        join
        chk(w, 32'h0000_002B);
        ask(1'b1, 0, w);
        chk(w, 32'h0000_0020);
        axi_rd(REG_IRQ_STAT, 32'h0000_0003, RESP_OKAY);
        axi_rd(REG_PHY, 32'h0000_017A, RESP_OKAY);
    endtask

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Hang guard
    initial begin
        #100000;
        err_total++;
        finish_test();
    end

    // Main sequence
    initial begin
        aresetn <= 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
        s_axi_awaddr <= 8'h0;
        s_axi_araddr <= 8'h0;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'hF;
        set_phy({2'b10, RATE_10M, 1'b0, 5'b11101});
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_irq();
        t_codes();
        t_flags();
        t_snap();
        finish_test();
    end
endmodule
`default_nettype wire
